// file: design/config_store.v
// Configuration word memory with one write port and a registered read port.
`default_nettype none
module config_store (
   input wire core_clk_i,
   input wire wr_en_i,
   input wire [7:0] wr_addr_i,
   input wire [31:0] wr_data_i,
   input wire rd_en_i,
   input wire [7:0] rd_addr_i,
   output reg [31:0] rd_data_o
);
   reg [31:0] mem [0:255];

   // Software writes a device's configuration word.
   always @(posedge core_clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   // Read data leaves through a register and holds until the next read.
   always @(posedge core_clk_i) begin
      if (rd_en_i) begin
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule
`default_nettype wire

// file: design/dummy_never.v
`default_nettype none
`default_nettype wire

// file: design/loop_supervisor.v
// Loop heartbeat generator, continuity checker and fault annunciator.
//
// The Wishbone interface to the registers and the register addresses are this design's own decisions.
`include "loop_supervisor_defs.vh"
`default_nettype none
module loop_supervisor #(
   parameter [24:0] HB_CYCLES = `HB_CYCLES
) (
   input wire core_clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg tx_a_valid_o,
   output reg [31:0] tx_a_data_o,
   output reg tx_b_valid_o,
   output reg [31:0] tx_b_data_o,
   input wire rx_a_valid_i,
   input wire rx_a_sof_i,
   input wire [31:0] rx_a_data_i,
   input wire rx_b_valid_i,
   input wire rx_b_sof_i,
   input wire [31:0] rx_b_data_i,
   input wire peer_ok_i,
   input wire [4:0] fault_pins_i,
   output reg trouble_led_o,
   output reg loop_fault_led_o,
   output reg trouble_relay_o,
   output reg master_o,
   output reg irq_o
);
   localparam S_IDLE = 3'd0;
   localparam S_HB_HDR = 3'd1;
   localparam S_HB_TIME = 3'd2;
   localparam S_CFG_RD = 3'd3;
   localparam S_CFG_HDR = 3'd4;
   localparam S_CFG_DAT = 3'd5;
   localparam [24:0] HB_LAST = HB_CYCLES - 25'd1;

   // Merges write data into a register under the byte enables.
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] sel;
      integer k;
      begin
         merge = old_v;
         for (k = 0; k < 4; k = k + 1) begin
            if (sel[k]) begin
               merge[k*8 +: 8] = new_v[k*8 +: 8];
            end
         end
      end
   endfunction

   // Extracts the message type from a header word.
   function [3:0] msg_type;
      input [31:0] w;
      begin
         msg_type = w[`HDR_TYPE_HI:`HDR_TYPE_LO];
      end
   endfunction

   reg [2:0] ctrl_q;
   reg [`ST_W-1:0] st_q;
   reg [`ST_W-1:0] st_d;
   reg [`ST_W-1:0] mask_q;
   reg [31:0] time_q;
   reg [31:0] event_q;
   reg [7:0] cfg_addr_q;
   reg [24:0] hb_cnt_q;
   reg tick_q;
   reg [7:0] seq_q;
   reg hb_pend_q;
   reg hb_sent_q;
   reg seen_ab_q;
   reg seen_ba_q;
   reg dl_pend_q;
   reg [7:0] dl_addr_q;
   reg dl_port_q;
   reg [2:0] state_q;
   reg [`SYNC_W-1:0] sync1_q;
   reg [`SYNC_W-1:0] sync2_q;
   reg [`SYNC_W-1:0] sync3_q;
   reg [`SYNC_W-1:0] filt_q;
   wire [31:0] cfg_rd_data;
   wire [1:0] rx_valid;
   wire [1:0] rx_sof;
   wire [63:0] rx_data;
   wire [1:0] hb_ret;
   wire [1:0] alarm_in;
   wire [1:0] fault_in;
   wire [1:0] hello_in;
   wire bus_req;
   wire bus_wr;
   wire peer_ok;
   wire is_master;
   wire dl_take;
   wire [`ST_W-1:0] st_set;
   wire [`ST_W-1:0] st_clr;
   wire [31:0] ctrl_wr;
   wire [31:0] mask_wr;
   wire [31:0] cfg_addr_wr;

   // Byte-merged write values, cut to each register's width.
   assign ctrl_wr = merge({29'h0, ctrl_q}, wb_dat_i, wb_sel_i);
   assign mask_wr = merge({23'h0, mask_q}, wb_dat_i, wb_sel_i);
   assign cfg_addr_wr = merge({24'h0, cfg_addr_q}, wb_dat_i, wb_sel_i);

   assign rx_valid = {rx_b_valid_i, rx_a_valid_i};
   assign rx_sof = {rx_b_sof_i, rx_a_sof_i};
   assign rx_data = {rx_b_data_i, rx_a_data_i};

   // Per-port receive decode; port 0 is A, port 1 is B.
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : rx_dec
         wire [31:0] w = rx_data[g*32 +: 32];
         wire hdr = rx_valid[g] & rx_sof[g];
         // A heartbeat sent out of the other port must come back here.
         assign hb_ret[g] = hdr & (msg_type(w) == `MSG_HB) & (w[`HDR_DIR] ^ (g == 1)) &
                            (w[`HDR_SEQ_HI:`HDR_SEQ_LO] == seq_q);
         assign alarm_in[g] = hdr & (msg_type(w) == `MSG_ALARM);
         assign fault_in[g] = hdr & (msg_type(w) == `MSG_STATUS) & (w[`HDR_CODE_HI:`HDR_CODE_LO] != 8'h00);
         assign hello_in[g] = hdr & (msg_type(w) == `MSG_HELLO);
      end
   endgenerate

   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_wr = bus_req & wb_we_i & wb_ack_o;
   assign peer_ok = filt_q[`SYNC_W-1];
   // Standby only when paired, asked to stand by, and the peer is alive.
   assign is_master = ~(ctrl_q[`CTRL_REDUN] & ctrl_q[`CTRL_STANDBY] & peer_ok);
   assign dl_take = (state_q == S_IDLE) & ~hb_pend_q & dl_pend_q & is_master & ctrl_q[`CTRL_PROG];

   // Events that set sticky status bits.
   assign st_set[`ST_LOOP] = tick_q & hb_sent_q & ~(seen_ab_q & seen_ba_q);
   assign st_set[`ST_DEVF] = |fault_in;
   assign st_set[`ST_ALARM] = |alarm_in;
   assign st_set[`ST_REDUN] = ctrl_q[`CTRL_REDUN] & ~peer_ok;
   assign st_set[`ST_W-1:`ST_PIN_LO] = filt_q[`PIN_W-1:0];
   assign st_clr = (bus_wr && {wb_adr_i[7:2], 2'b00} == `REG_STATUS) ?
                   (wb_dat_i[`ST_W-1:0] & {1'b1, {8{wb_sel_i[0]}}} & {wb_sel_i[1], 8'hff}) : {`ST_W{1'b0}};

   // Sticky status; a new event wins over a clear in the same cycle.
   always @* begin
      st_d = (st_q & ~st_clr) | st_set;
   end

   // Pin inputs pass three flops; a change counts once the last two agree.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         sync1_q <= {`SYNC_W{1'b0}};
         sync2_q <= {`SYNC_W{1'b0}};
         sync3_q <= {`SYNC_W{1'b0}};
         filt_q <= {`SYNC_W{1'b0}};
      end else begin
         sync1_q <= {peer_ok_i, fault_pins_i};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         filt_q <= (sync2_q & sync3_q) | (filt_q & (sync2_q | sync3_q));
      end
   end

   // One-second time base and the time-of-day counter.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         hb_cnt_q <= 25'd0;
         tick_q <= 1'b0;
         time_q <= `TIME_RST;
      end else begin
         tick_q <= (hb_cnt_q == HB_LAST);
         hb_cnt_q <= (hb_cnt_q == HB_LAST) ? 25'd0 : hb_cnt_q + 25'd1;
         if (bus_wr && {wb_adr_i[7:2], 2'b00} == `REG_TIME) begin
            time_q <= merge(time_q, wb_dat_i, wb_sel_i);
         end else if (tick_q) begin
            time_q <= time_q + 32'd1;
         end
      end
   end

   // Heartbeat scheduling and return tracking for both directions.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         seq_q <= 8'h00;
         hb_pend_q <= 1'b0;
         hb_sent_q <= 1'b0;
         seen_ab_q <= 1'b0;
         seen_ba_q <= 1'b0;
      end else begin
         if (tick_q) begin
            seq_q <= seq_q + 8'h01;
            hb_sent_q <= 1'b0;
            seen_ab_q <= 1'b0;
            seen_ba_q <= 1'b0;
         end else begin
            hb_sent_q <= hb_sent_q | (state_q == S_HB_HDR);
            seen_ab_q <= seen_ab_q | hb_ret[1];
            seen_ba_q <= seen_ba_q | hb_ret[0];
         end
         if (!is_master) begin
            hb_pend_q <= 1'b0;
         end else if (tick_q) begin
            hb_pend_q <= 1'b1;
         end else if (state_q == S_HB_HDR) begin
            hb_pend_q <= 1'b0;
         end
      end
   end

   // Holds one pending configuration download for a device that said hello.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         dl_pend_q <= 1'b0;
         dl_addr_q <= 8'h00;
         dl_port_q <= 1'b0;
      end else if ((|hello_in) && (!dl_pend_q || dl_take)) begin
         dl_pend_q <= 1'b1;
         dl_port_q <= ~hello_in[0];
         dl_addr_q <= hello_in[0] ? rx_a_data_i[`HDR_ADDR_HI:`HDR_ADDR_LO] : rx_b_data_i[`HDR_ADDR_HI:`HDR_ADDR_LO];
      end else if (dl_take) begin
         dl_pend_q <= 1'b0;
      end
   end

   // Transmit sequencer: heartbeat on both ports, downloads on one.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         tx_a_valid_o <= 1'b0;
         tx_b_valid_o <= 1'b0;
         tx_a_data_o <= 32'h00000000;
         tx_b_data_o <= 32'h00000000;
      end else begin
         tx_a_valid_o <= 1'b0;
         tx_b_valid_o <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (hb_pend_q && is_master) begin
                  state_q <= S_HB_HDR;
               end else if (dl_take) begin
                  state_q <= S_CFG_RD;
               end
            end
            S_HB_HDR: begin
               tx_a_valid_o <= 1'b1;
               tx_b_valid_o <= 1'b1;
               tx_a_data_o <= {`MSG_HB, 1'b0, 3'h0, seq_q, 16'h0000};
               tx_b_data_o <= {`MSG_HB, 1'b1, 3'h0, seq_q, 16'h0000};
               state_q <= S_HB_TIME;
            end
            S_HB_TIME: begin
               tx_a_valid_o <= 1'b1;
               tx_b_valid_o <= 1'b1;
               tx_a_data_o <= time_q;
               tx_b_data_o <= time_q;
               state_q <= S_IDLE;
            end
            S_CFG_RD: begin
               state_q <= S_CFG_HDR;
            end
            S_CFG_HDR: begin
               tx_a_valid_o <= ~dl_port_q;
               tx_b_valid_o <= dl_port_q;
               tx_a_data_o <= {`MSG_CFG, 12'h000, dl_addr_q, 8'h00};
               tx_b_data_o <= {`MSG_CFG, 12'h000, dl_addr_q, 8'h00};
               state_q <= S_CFG_DAT;
            end
            S_CFG_DAT: begin
               tx_a_valid_o <= ~dl_port_q;
               tx_b_valid_o <= dl_port_q;
               tx_a_data_o <= cfg_rd_data;
               tx_b_data_o <= cfg_rd_data;
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   config_store u_store (
      .core_clk_i(core_clk_i),
      .wr_en_i(bus_wr && {wb_adr_i[7:2], 2'b00} == `REG_CFG_DATA),
      .wr_addr_i(cfg_addr_q),
      .wr_data_i(wb_dat_i),
      .rd_en_i(state_q == S_CFG_RD),
      .rd_addr_i(dl_addr_q),
      .rd_data_o(cfg_rd_data)
   );

   // Status, indicators, relay and interrupt, all from flops.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         st_q <= `ST_RST;
         trouble_led_o <= 1'b0;
         loop_fault_led_o <= 1'b0;
         trouble_relay_o <= 1'b0;
         master_o <= 1'b0;
         irq_o <= 1'b0;
         event_q <= 32'h00000000;
      end else begin
         st_q <= st_d;
         trouble_led_o <= |(st_d & `TROUBLE_BITS);
         loop_fault_led_o <= st_d[`ST_LOOP];
         trouble_relay_o <= ~|(st_d & `TROUBLE_BITS);
         master_o <= is_master;
         irq_o <= |(st_d & mask_q);
         if (alarm_in[0] || alarm_in[1]) begin
            event_q[7:0] <= alarm_in[0] ? rx_a_data_i[`HDR_ADDR_HI:`HDR_ADDR_LO] : rx_b_data_i[`HDR_ADDR_HI:`HDR_ADDR_LO];
         end
         if (fault_in[0] || fault_in[1]) begin
            event_q[31:8] <= fault_in[0] ? {8'h00, rx_a_data_i[15:0]} : {8'h00, rx_b_data_i[15:0]};
         end
      end
   end

   // Wishbone slave: ack one cycle after the strobe, writes at the acked edge.
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         ctrl_q <= `CTRL_RST;
         mask_q <= `MASK_RST;
         cfg_addr_q <= 8'h00;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req && !wb_ack_o) begin
            case ({wb_adr_i[7:2], 2'b00})
               `REG_CTRL: wb_dat_o <= {29'h0, ctrl_q};
               `REG_STATUS: wb_dat_o <= {23'h0, st_q};
               `REG_MASK: wb_dat_o <= {23'h0, mask_q};
               `REG_TIME: wb_dat_o <= time_q;
               `REG_EVENT: wb_dat_o <= event_q;
               `REG_CFG_ADDR: wb_dat_o <= {24'h0, cfg_addr_q};
               `REG_STATE: wb_dat_o <= {16'h0, seq_q, 4'h0, dl_pend_q, (state_q != S_IDLE), peer_ok, is_master};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
         if (bus_wr) begin
            case ({wb_adr_i[7:2], 2'b00})
               `REG_CTRL: ctrl_q <= ctrl_wr[2:0];
               `REG_MASK: mask_q <= mask_wr[`ST_W-1:0];
               `REG_CFG_ADDR: cfg_addr_q <= cfg_addr_wr[7:0];
               default: cfg_addr_q <= cfg_addr_q;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: design/loop_supervisor_defs.vh
// Constants for the loop heartbeat and fault supervisor.
`ifndef LOOP_SUPERVISOR_DEFS_VH
`define LOOP_SUPERVISOR_DEFS_VH

// Register byte offsets.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_TIME 8'h0c
`define REG_EVENT 8'h10
`define REG_CFG_ADDR 8'h14
`define REG_CFG_DATA 8'h18
`define REG_STATE 8'h1c

// Control register bits and reset value.
`define CTRL_REDUN 0
`define CTRL_STANDBY 1
`define CTRL_PROG 2
`define CTRL_W 3
`define CTRL_RST 3'h0

// Status and mask bits, width and reset values.
`define ST_LOOP 0
`define ST_DEVF 1
`define ST_ALARM 2
`define ST_REDUN 3
`define ST_PIN_LO 4
`define ST_W 9
`define ST_RST 9'h000
`define MASK_RST 9'h000
`define TROUBLE_BITS 9'h1fb
`define TIME_RST 32'h00000000

// External fault pins and synchroniser width.
`define PIN_W 5
`define SYNC_W 6

// Message header fields.
`define HDR_TYPE_HI 31
`define HDR_TYPE_LO 28
`define HDR_DIR 27
`define HDR_SEQ_HI 23
`define HDR_SEQ_LO 16
`define HDR_ADDR_HI 15
`define HDR_ADDR_LO 8
`define HDR_CODE_HI 7
`define HDR_CODE_LO 0

// Message type codes.
`define MSG_HB 4'h1
`define MSG_CFG 4'h2
`define MSG_ALARM 4'h3
`define MSG_STATUS 4'h4
`define MSG_HELLO 4'h5

// Heartbeat timing.
`define HB_PERIOD_MS 1000
`define CORE_CLK_KHZ 25000
`define HB_CYCLES (25'd`HB_PERIOD_MS * 25'd`CORE_CLK_KHZ)

`endif

// file: verif/loop_field_devices.sv
// Ring of field devices: loops words port to port and injects device messages.
`default_nettype none
module loop_field_devices #(
   parameter logic [7:0] DEV_ADDR = 8'h2a,
   parameter int LOSS_CYCLES = 300,
   parameter int MAX_SWAPS = 7
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic tx_a_valid_o,
   input wire logic [31:0] tx_a_data_o,
   input wire logic tx_b_valid_o,
   input wire logic [31:0] tx_b_data_o,
   input wire logic cut_i,
   input wire logic inj_i,
   input wire logic [31:0] inj_hdr_i,
   output logic rx_a_valid_i = 1'b0,
   output logic rx_a_sof_i = 1'b0,
   output logic [31:0] rx_a_data_i = 32'h0,
   output logic rx_b_valid_i = 1'b0,
   output logic rx_b_sof_i = 1'b0,
   output logic [31:0] rx_b_data_i = 32'h0,
   output logic cfg_seen_o,
   output logic [31:0] cfg_word_o,
   output logic [1:0] iso_o
);
   logic pa_q, pb_q, ia_q, cw_q;
   int quiet_q, swaps_q;
   wire heard = !cut_i && (tx_a_valid_o && !pa_q && tx_a_data_o[31:28] == 4'h1 && !iso_o[0]
                || tx_b_valid_o && !pb_q && tx_b_data_o[31:28] == 4'h1 && !iso_o[1]);
   // Heartbeat silence starts isolation; further silent periods swap the open side until MAX_SWAPS, then isolation ends.
   always @(posedge core_clk_i) begin
      if (rst_i || heard) begin
         quiet_q <= 0;
         swaps_q <= 0;
         iso_o <= 2'b00;
      end else if (quiet_q < LOSS_CYCLES - 1) begin
         quiet_q <= quiet_q + 1;
      end else if (swaps_q < MAX_SWAPS) begin
         quiet_q <= 0;
         swaps_q <= swaps_q + 1;
         iso_o <= swaps_q[0] ? 2'b10 : 2'b01;
      end else begin
         iso_o <= 2'b00;
      end
   end
   // Phase bits mark headers of two-word messages; the device addressed by its switches takes its config.
   always @(posedge core_clk_i) begin
      pa_q <= !rst_i && (pa_q ^ tx_a_valid_o);
      pb_q <= !rst_i && (pb_q ^ tx_b_valid_o);
      ia_q <= inj_i;
      cw_q <= tx_a_valid_o && !pa_q && tx_a_data_o[31:28] == 4'h2 && tx_a_data_o[15:8] == DEV_ADDR;
      if (rst_i) begin
         cfg_seen_o <= 1'b0;
      end else if (cw_q && tx_a_valid_o) begin
         cfg_seen_o <= 1'b1;
         cfg_word_o <= tx_a_data_o;
      end
   end
   // Words cross the ring in a cycle unless cut; idle lines toggle between the last word and its inverse.
   always @(posedge core_clk_i) begin
      rx_b_valid_i <= tx_a_valid_o && !cut_i && !rst_i;
      rx_b_sof_i <= tx_a_valid_o && !pa_q && !cut_i;
      rx_b_data_i <= tx_a_valid_o ? tx_a_data_o : ~rx_b_data_i;
      rx_a_valid_i <= (tx_b_valid_o && !cut_i || inj_i || ia_q) && !rst_i;
      rx_a_sof_i <= inj_i || tx_b_valid_o && !pb_q && !cut_i;
      rx_a_data_i <= inj_i ? inj_hdr_i : ia_q ? 32'h0 : tx_b_valid_o ? tx_b_data_o : ~rx_a_data_i;
   end
endmodule
`default_nettype wire

// file: verif/loop_supervisor_monitor.sv
// Concurrent checks on the loop supervisor ports.
`default_nettype none
module loop_supervisor_monitor #(
   parameter [24:0] HB_CYCLES = 25'd200
) (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic tx_a_valid_o,
   input wire logic [31:0] tx_a_data_o,
   input wire logic tx_b_valid_o,
   input wire logic [31:0] tx_b_data_o,
   input wire logic [4:0] fault_pins_i,
   input wire logic trouble_led_o,
   input wire logic loop_fault_led_o,
   input wire logic trouble_relay_o,
   input wire logic master_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic [24:0] gap_q;
   logic seen_q;
   logic ph_q;
   logic [7:0] seq_q;
   wire hdr = tx_a_valid_o && !ph_q;
   wire hb = hdr && tx_a_data_o[31:28] == 4'h1;
   // Tracks word phase on port A and the distance between heartbeat headers.
   always_ff @(posedge core_clk_i) begin
      ph_q <= rst_i ? 1'b0 : ph_q ^ tx_a_valid_o;
      if (rst_i || !master_o) begin
         gap_q <= 25'd0;
         seen_q <= 1'b0;
      end else begin
         gap_q <= hb ? 25'd0 : gap_q + 25'd1;
         seen_q <= seen_q || hb;
      end
      if (hb) begin
         seq_q <= tx_a_data_o[23:16];
      end
   end
   chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   chk_hb_period: assert property (hb && seen_q |-> gap_q == HB_CYCLES - 25'd1
      && tx_a_data_o[23:16] == seq_q + 8'd1) else $error("heartbeat spacing or sequence wrong");
   chk_hb_steady: assert property (seen_q |-> gap_q < HB_CYCLES)
      else $error("heartbeat stopped");
   chk_hb_both: assert property (hb |-> tx_b_valid_o && tx_b_data_o[31:27] == 5'h03
      && !tx_a_data_o[27] && tx_b_data_o[23:16] == tx_a_data_o[23:16]
      ##1 tx_a_valid_o && tx_b_valid_o && tx_a_data_o == tx_b_data_o) else $error("heartbeat pair wrong");
   chk_relay_healthy: assert property (!$past(rst_i) |-> trouble_relay_o == !trouble_led_o)
      else $error("relay disagrees with trouble");
   chk_loop_trouble: assert property (loop_fault_led_o |-> trouble_led_o)
      else $error("loop fault without trouble");
   chk_pin_trouble: assert property ((fault_pins_i != 5'h0) [*8] |-> ##2 trouble_led_o && !trouble_relay_o)
      else $error("fault pin not annunciated");
   chk_standby_quiet: assert property ((!master_o) [*6] |-> !tx_a_valid_o && !tx_b_valid_o)
      else $error("standby transmits");
   chk_cfg_word: assert property (hdr && tx_a_data_o[31:28] == 4'h2 |=> tx_a_valid_o)
      else $error("download word missing");
   cov_heartbeat: cover property (hb && seen_q);
   cov_loop_fault: cover property ($rose(loop_fault_led_o));
   cov_download: cover property (hdr && tx_a_data_o[31:28] == 4'h2);
   cov_standby: cover property ((!master_o) [*6]);
endmodule
bind loop_supervisor loop_supervisor_monitor #(.HB_CYCLES(HB_CYCLES)) mon (.*);
`default_nettype wire

// file: verif/test_loop_supervisor.sv
// Randomised self-checking bench for the loop supervisor.
`default_nettype none
module test_loop_supervisor;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, peer_ok_i = 0, cut_i = 0, inj_i = 0;
   logic [7:0] wb_adr_i = '0, a;
   logic [3:0] wb_sel_i = '0;
   logic [4:0] fault_pins_i = '0;
   logic [31:0] wb_dat_i = '0, inj_hdr_i = '0, rdat, h, t;
   logic [31:0] wb_dat_o, tx_a_data_o, tx_b_data_o, rx_a_data_i, rx_b_data_i, cfg_word_o;
   logic wb_ack_o, tx_a_valid_o, tx_b_valid_o, rx_a_valid_i, rx_b_valid_i, rx_a_sof_i, rx_b_sof_i;
   logic trouble_led_o, loop_fault_led_o, trouble_relay_o, master_o, irq_o, cfg_seen_o;
   logic [1:0] iso_o;
   int n_errors = 0, num_checks = 0, n;
   loop_supervisor #(.HB_CYCLES(25'd200)) uut (.*);
   loop_field_devices dev (.*);
   initial forever #20 core_clk_i = ~core_clk_i;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] v);
      @(posedge core_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= ad;
      wb_dat_i <= v;
      wb_sel_i <= 4'hf;
      do @(posedge core_clk_i); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wait_hb;
      do @(posedge core_clk_i); while (!(tx_a_valid_o === 1'b1 && tx_a_data_o[31:28] === 4'h1));
   endtask
   task automatic send(input logic [31:0] hd);
      wait_hb;
      repeat (10) @(posedge core_clk_i);
      inj_i <= 1'b1;
      inj_hdr_i <= hd;
      @(posedge core_clk_i);
      inj_i <= 1'b0;
      repeat (4) @(posedge core_clk_i);
   endtask
   task automatic end_of_test;
      if (n_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #(40 * 30000);
      n_errors++;
      end_of_test;
   end
   initial begin
      void'($urandom(32'h9c9c3482));
      repeat (5) @(posedge core_clk_i);
      chk(trouble_relay_o, 1'b0);
      rst_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      chk({master_o, trouble_relay_o, trouble_led_o}, 3'b110);
      for (n = 0; n <= 32; n += 8) begin
         wb(1'b0, n[7:0], '0);
         chk(rdat, '0);
      end
      t = $urandom;
      wb(1'b1, 8'h0c, t);
      wait_hb;
      h = tx_a_data_o;
      chk(h[31:27], 5'h02);
      chk({tx_b_valid_o, tx_b_data_o[31:27], tx_b_data_o[23:16]}, {6'h23, h[23:16]});
      @(posedge core_clk_i);
      chk(tx_a_data_o, t + 32'h1);
      chk(tx_b_data_o, t + 32'h1);
      wait_hb;
      @(posedge core_clk_i);
      chk(tx_a_data_o, t + 32'h2);
      repeat (4) @(posedge core_clk_i);
      chk(loop_fault_led_o, 1'b0);
      cut_i <= 1'b1;
      wait_hb;
      wait_hb;
      repeat (4) @(posedge core_clk_i);
      chk({loop_fault_led_o, trouble_led_o, trouble_relay_o}, 3'b110);
      chk(iso_o, 2'b01);
      cut_i <= 1'b0;
      wait_hb;
      repeat (20) @(posedge core_clk_i);
      chk(iso_o, 2'b00);
      wb(1'b1, 8'h04, 32'h1);
      wait_hb;
      repeat (4) @(posedge core_clk_i);
      wb(1'b0, 8'h04, '0);
      chk({rdat[8:0], trouble_relay_o}, 10'h001);
      wb(1'b1, 8'h08, 32'h4);
      a = $urandom;
      send({4'h3, 12'h0, a, 8'h01});
      chk({irq_o, trouble_led_o}, 2'b10);
      wb(1'b0, 8'h10, '0);
      chk(rdat[7:0], a);
      wb(1'b1, 8'h08, 32'h0);
      wb(1'b0, 8'h04, '0);
      chk({rdat[2], irq_o}, 2'b10);
      wb(1'b1, 8'h04, 32'h4);
      send({4'h4, 12'h0, a, 8'h5a});
      chk({trouble_led_o, trouble_relay_o, loop_fault_led_o}, 3'b100);
      wb(1'b1, 8'h04, 32'h2);
      for (n = 0; n < 5; n++) begin
         fault_pins_i <= 5'h01 << n;
         repeat (12) @(posedge core_clk_i);
         wb(1'b0, 8'h04, '0);
         chk({rdat[8:0], loop_fault_led_o, trouble_led_o}, {9'h010 << n, 2'b01});
         fault_pins_i <= 5'h0;
         repeat (8) @(posedge core_clk_i);
         wb(1'b1, 8'h04, 32'h1f0);
      end
      wb(1'b1, 8'h00, 32'h1);
      repeat (8) @(posedge core_clk_i);
      wb(1'b0, 8'h04, '0);
      chk(rdat[3], 1'b1);
      peer_ok_i <= 1'b1;
      wb(1'b1, 8'h00, 32'h3);
      repeat (8) @(posedge core_clk_i);
      chk(master_o, 1'b0);
      for (n = 0; n < 250; n++) begin
         @(posedge core_clk_i);
         chk(tx_a_valid_o, 1'b0);
      end
      wb(1'b1, 8'h00, 32'h4);
      wb(1'b1, 8'h04, 32'h8);
      h = $urandom;
      wb(1'b1, 8'h14, 32'h2a);
      wb(1'b1, 8'h18, h);
      send({4'h5, 12'h0, 8'h2a, 8'h00});
      repeat (10) @(posedge core_clk_i);
      chk({cfg_seen_o, master_o}, 2'b11);
      chk(cfg_word_o, h);
      end_of_test;
   end
endmodule
`default_nettype wire
